/* File: src/timer_unit_pkg.sv */
// Behaviour
// - three independent timers, 16-bit counts each
// - timers 0 and 1 own input and output pins
// - timer 1 terminal count raises watchdog interrupt
// - timer 2 pinless, prescales timers, requests DMA
// - eleven 16-bit control registers
// - counts readable and writable at any time
// - each qualifying event adds one to count
// - count reaching maximum returns to zero immediately
// - timers 0 and 1 alternate two maxima
// - single maximum: output low one clock
// - dual maxima: output shows governing maximum
// - each timer serviced every fourth clock
// - external clock at most quarter rate, six-clock lag
package timer_unit_pkg;
    // register indices on the write and read select ports
    localparam logic [3:0] REG_T0_COUNT = 4'h0;
    localparam logic [3:0] REG_T0_MAX_A = 4'h1;
    localparam logic [3:0] REG_T0_MAX_B = 4'h2;
    localparam logic [3:0] REG_T0_CTL = 4'h3;
    localparam logic [3:0] REG_T1_COUNT = 4'h4;
    localparam logic [3:0] REG_T1_MAX_A = 4'h5;
    localparam logic [3:0] REG_T1_MAX_B = 4'h6;
    localparam logic [3:0] REG_T1_CTL = 4'h7;
    localparam logic [3:0] REG_T2_COUNT = 4'h8;
    localparam logic [3:0] REG_T2_MAX_A = 4'h9;
    localparam logic [3:0] REG_T2_CTL = 4'hA;
    // register slot inside one timer
    localparam logic [1:0] LOC_COUNT = 2'h0;
    localparam logic [1:0] LOC_MAX_A = 2'h1;
    localparam logic [1:0] LOC_MAX_B = 2'h2;
    localparam logic [1:0] LOC_CTL = 2'h3;
    // control word bit positions
    localparam int CTL_CONT_BIT = 0;
    localparam int CTL_ALT_BIT = 1;
    localparam int CTL_EXT_BIT = 2;
    localparam int CTL_PRE_BIT = 3;
    localparam int CTL_MC_BIT = 5;
    localparam int CTL_RIU_BIT = 12;
    localparam int CTL_WDOG_BIT = 13;
    localparam int CTL_EN_BIT = 15;
    // reset values
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] MAX_RESET = 16'h0000;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    // timing
    localparam int SERVICE_PHASES = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam int OUT_LAG_MAX = 6;
endpackage

/* File: src/timer_channel.sv */
`timescale 1ns/1ps
module timer_channel
    import timer_unit_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter bit HAS_ALT = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_service,
    input wire logic i_ext_event,
    input wire logic i_pre_event,
    input wire logic i_wr_en,
    input wire logic [1:0] i_wr_reg,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic [WIDTH-1:0] o_count,
    output logic [WIDTH-1:0] o_max_a,
    output logic [WIDTH-1:0] o_max_b,
    output logic [WIDTH-1:0] o_ctl,
    output logic o_out,
    output logic o_tc
);
    // control bits sit up to bit 15, so narrower words cannot work
    generate
        if (WIDTH < 16) begin : g_bad_width
            $error("timer_channel: WIDTH must be at least 16");
        end
    endgenerate

    logic [WIDTH-1:0] next_count;
    logic [WIDTH-1:0] next_ctl;
    logic next_out;

    // write decode
    wire wr_count = i_wr_en && (i_wr_reg == LOC_COUNT);
    wire wr_max_a = i_wr_en && (i_wr_reg == LOC_MAX_A);
    wire wr_max_b = i_wr_en && HAS_ALT && (i_wr_reg == LOC_MAX_B);
    wire wr_ctl = i_wr_en && (i_wr_reg == LOC_CTL);

    // active maximum and event qualification
    wire alt_on = HAS_ALT && o_ctl[CTL_ALT_BIT];
    wire riu = o_ctl[CTL_RIU_BIT];
    wire [WIDTH-1:0] max_act = (alt_on && riu) ? o_max_b : o_max_a;
    wire evt = o_ctl[CTL_EXT_BIT] ? i_ext_event :
               o_ctl[CTL_PRE_BIT] ? i_pre_event : 1'b1;
    // software write of the count wins over a step in the same cycle
    wire step = i_service && o_ctl[CTL_EN_BIT] && evt && !wr_count;
    wire [WIDTH-1:0] inc = o_count + 1'b1;
    wire fire = step && (inc == max_act);
    wire next_riu = alt_on && (fire ? !riu : riu);
    wire stop = fire && !o_ctl[CTL_CONT_BIT] && (!alt_on || riu);

    // count: zero on reaching the maximum, never the maximum itself
    assign next_count = wr_count ? i_wr_data :
                        fire ? '0 :
                        step ? inc : o_count;
    // alternating: level shows the governing maximum; else a low pulse
    assign next_out = alt_on ? !next_riu : !fire;

    // control word; the reached-max flag set wins over a write clearing it
    always_comb begin
        next_ctl = wr_ctl ? i_wr_data : o_ctl;
        if (!wr_ctl && stop) begin
            next_ctl[CTL_EN_BIT] = 1'b0;
        end
        next_ctl[CTL_RIU_BIT] = next_riu;
        next_ctl[CTL_MC_BIT] = next_ctl[CTL_MC_BIT] | fire;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_count <= COUNT_RESET;
            o_max_a <= MAX_RESET;
            o_max_b <= MAX_RESET;
            o_ctl <= CTL_RESET;
            o_out <= 1'b1;
            o_tc <= 1'b0;
        end else begin
            o_count <= next_count;
            if (wr_max_a) begin
                o_max_a <= i_wr_data;
            end
            if (wr_max_b) begin
                o_max_b <= i_wr_data;
            end
            o_ctl <= next_ctl;
            o_out <= next_out;
            o_tc <= fire;
        end
    end

    // properties next to the count, limit and output logic
    a_count_wrap: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        fire |=> (o_count == '0) && o_tc)
        else $error("count did not wrap to zero at maximum");
    a_count_step: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        step && !fire |=> o_count == $past(inc) && !o_tc)
        else $error("count did not advance by one");
    a_count_hold: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        !i_service && !wr_count |=> $stable(o_count))
        else $error("count moved outside its service slot");
    a_count_write: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        wr_count |=> o_count == $past(i_wr_data))
        else $error("count write was lost");
    a_alt_swap: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        fire && alt_on |=> o_ctl[CTL_RIU_BIT] != $past(riu))
        else $error("maximum did not alternate");
    a_out_pulse: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        fire && !alt_on |=> !o_out ##1 o_out)
        else $error("output low pulse not exactly one clock");
    a_alt_level: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        alt_on |=> o_out == !o_ctl[CTL_RIU_BIT])
        else $error("output level does not show governing maximum");
endmodule

/* File: src/triple_timer_unit.sv */
`timescale 1ns/1ps
module triple_timer_unit
    import timer_unit_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_wr_en,
    input wire logic [3:0] i_wr_sel,
    input wire logic [WIDTH-1:0] i_wr_data,
    input wire logic [3:0] i_rd_sel,
    output logic [WIDTH-1:0] o_rd_data,
    input wire logic i_timer0_in,
    input wire logic i_timer1_in,
    output logic o_timer0_out,
    output logic o_timer1_out,
    output logic o_timer1_watchdog_irq_source,
    output logic o_timer2_dma_req,
    output logic [2:0] o_timer_tc
);
    import timer_unit_pkg::*;

    generate
        if (WIDTH != 16) begin : g_bad_width
            $error("triple_timer_unit: WIDTH must be 16");
        end
    endgenerate

    logic [1:0] phase;
    logic [1:0] in_meta;
    logic [1:0] in_sync;
    logic [1:0] in_last;
    logic [1:0] ext_pend;
    logic [1:0] pre_pend;
    logic [WIDTH-1:0] rd_mux;
    logic [2:0][WIDTH-1:0] count;
    logic [2:0][WIDTH-1:0] max_a;
    logic [2:0][WIDTH-1:0] max_b;
    logic [2:0][WIDTH-1:0] ctl;
    logic [2:0] out;
    logic [2:0] tc;

    // one timer per clock slot, each seen once every fourth clock
    wire [2:0] service;
    assign service[0] = (phase == 2'h0);
    assign service[1] = (phase == 2'h1);
    assign service[2] = (phase == 2'h2);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase <= 2'h0;
        end else begin
            phase <= (phase == PHASE_LAST) ? 2'h0 : phase + 2'h1;
        end
    end

    // pin synchroniser; the second and third stages feed edge detection, never the first
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            in_meta <= 2'h0;
            in_sync <= 2'h0;
            in_last <= 2'h0;
        end else begin
            in_meta <= {i_timer1_in, i_timer0_in};
            in_sync <= in_meta;
            in_last <= in_sync;
        end
    end

    wire [1:0] ext_edge = in_sync & ~in_last;

    // edges and prescale ticks wait for the timer's slot; the event
    // also passes straight through so nothing is delayed a full round
    wire [1:0] ext_event = ext_pend | ext_edge;
    wire [1:0] pre_event = pre_pend | {tc[2], tc[2]};

    // a faster pin clock merges edges in one slot: quarter rate limit
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ext_pend <= 2'h0;
            pre_pend <= 2'h0;
        end else begin
            ext_pend <= ext_event & ~service[1:0];
            pre_pend <= pre_event & ~service[1:0];
        end
    end

    // write decode: select bits 3:2 pick the timer, 1:0 the slot, except index A, which goes to timer 2's control slot, and indices B to F, which are dropped
    wire [1:0] wr_loc = (i_wr_sel == REG_T2_CTL) ? LOC_CTL : i_wr_sel[1:0];
    wire [2:0] wr_hit;
    assign wr_hit[0] = i_wr_en && (i_wr_sel[3:2] == 2'h0);
    assign wr_hit[1] = i_wr_en && (i_wr_sel[3:2] == 2'h1);
    assign wr_hit[2] = i_wr_en && ((i_wr_sel == REG_T2_COUNT) ||
                       (i_wr_sel == REG_T2_MAX_A) ||
                       (i_wr_sel == REG_T2_CTL));

    // timers with pins and two maxima
    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_pin_timer
            timer_channel #(
                .WIDTH(WIDTH),
                .HAS_ALT(1'b1)
            ) u_timer (
                .i_clk(i_clk),
                .i_reset_n(i_reset_n),
                .i_service(service[t]),
                .i_ext_event(ext_event[t]),
                .i_pre_event(pre_event[t]),
                .i_wr_en(wr_hit[t]),
                .i_wr_reg(wr_loc),
                .i_wr_data(i_wr_data),
                .o_count(count[t]),
                .o_max_a(max_a[t]),
                .o_max_b(max_b[t]),
                .o_ctl(ctl[t]),
                .o_out(out[t]),
                .o_tc(tc[t])
            );
        end
    endgenerate

    // pinless timer, single maximum only
    timer_channel #(
        .WIDTH(WIDTH),
        .HAS_ALT(1'b0)
    ) u_timer2 (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_service(service[2]),
        .i_ext_event(1'b0),
        .i_pre_event(1'b0),
        .i_wr_en(wr_hit[2]),
        .i_wr_reg(wr_loc),
        .i_wr_data(i_wr_data),
        .o_count(count[2]),
        .o_max_a(max_a[2]),
        .o_max_b(max_b[2]),
        .o_ctl(ctl[2]),
        .o_out(out[2]),
        .o_tc(tc[2])
    );

    // read select; unmapped indices read zero
    always_comb begin
        case (i_rd_sel)
            REG_T0_COUNT: rd_mux = count[0];
            REG_T0_MAX_A: rd_mux = max_a[0];
            REG_T0_MAX_B: rd_mux = max_b[0];
            REG_T0_CTL: rd_mux = ctl[0];
            REG_T1_COUNT: rd_mux = count[1];
            REG_T1_MAX_A: rd_mux = max_a[1];
            REG_T1_MAX_B: rd_mux = max_b[1];
            REG_T1_CTL: rd_mux = ctl[1];
            REG_T2_COUNT: rd_mux = count[2];
            REG_T2_MAX_A: rd_mux = max_a[2];
            REG_T2_CTL: rd_mux = ctl[2];
            default: rd_mux = '0;
        endcase
    end

    wire wdog_fire = tc[1] && ctl[1][CTL_WDOG_BIT];

    // outputs all registered, one clock behind the timer state
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_data <= '0;
            o_timer0_out <= 1'b1;
            o_timer1_out <= 1'b1;
            o_timer1_watchdog_irq_source <= 1'b0;
            o_timer2_dma_req <= 1'b0;
            o_timer_tc <= 3'h0;
        end else begin
            o_rd_data <= rd_mux;
            o_timer0_out <= out[0];
            o_timer1_out <= out[1];
            o_timer1_watchdog_irq_source <= wdog_fire;
            o_timer2_dma_req <= tc[2];
            o_timer_tc <= tc;
        end
    end

    // slot order, synchroniser depth and the port pulses
    a_service_slot: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        service[0] |-> ##1 service[1] ##1 service[2]
            ##1 !(|service) ##1 service[0])
        else $error("timer service slots out of order");
    a_sync_path: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        ext_edge[0] |-> $past(i_timer0_in, 2) && !$past(i_timer0_in, 3))
        else $error("pin edge not two synchroniser stages late");
    a_wdog_irq: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        tc[1] && ctl[1][CTL_WDOG_BIT] |=> o_timer1_watchdog_irq_source)
        else $error("watchdog interrupt missed timer 1 terminal count");
    a_wdog_quiet: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        !tc[1] |=> !o_timer1_watchdog_irq_source)
        else $error("watchdog interrupt without terminal count");
    a_dma_req: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        tc[2] |=> o_timer2_dma_req ##1 !o_timer2_dma_req)
        else $error("dma request not a one-clock pulse");
    // the tick lands in the phase-3 gap, so it must still stand at slot 0
    a_pre_count: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        tc[2] && ctl[0][CTL_EN_BIT] && ctl[0][CTL_PRE_BIT] &&
        !ctl[0][CTL_EXT_BIT] && !i_wr_en |=> service[0] && pre_event[0])
        else $error("prescale tick not held for its slot");

    // masking, quiet pulses, second pin and the read path
    a_wdog_mask: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        !ctl[1][CTL_WDOG_BIT] |=> !o_timer1_watchdog_irq_source)
        else $error("watchdog interrupt while masked");
    a_dma_quiet: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        !tc[2] |=> !o_timer2_dma_req)
        else $error("dma request without timer 2 terminal count");
    a_t2_single: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        ctl[2][CTL_EN_BIT] |-> !ctl[2][CTL_RIU_BIT])
        else $error("pinless timer switched to a second maximum");
    a_sync_pin1: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        ext_edge[1] |-> $past(i_timer1_in, 2) && !$past(i_timer1_in, 3))
        else $error("timer 1 pin edge not two stages late");
    a_rd_unmapped: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        i_rd_sel > REG_T2_CTL |=> o_rd_data == '0)
        else $error("unmapped register index read nonzero");
    a_rd_count: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        i_rd_sel == REG_T1_COUNT |=> o_rd_data == $past(count[1]))
        else $error("timer 1 count not shown on read port");
endmodule

/* File: verification/pin_pulse_model.sv */
`timescale 1ns/1ps
module pin_pulse_model (
    input wire logic i_clk,
    input wire logic i_run,
    input wire logic [3:0] i_period,
    output logic o_pin
);
    logic [3:0] span;
    logic [3:0] k;
    // never faster than a quarter of the device clock
    assign span = (i_period < 4'h4) ? 4'h4 : i_period;
    initial begin
        k = 4'h0;
        o_pin = 1'b0;
    end
    // one rising edge per span, launched off the falling edge; low when idle
    always @(negedge i_clk) begin
        if (!i_run) begin
            k <= 4'h0;
            o_pin <= 1'b0;
        end else begin
            k <= (k + 4'h1 >= span) ? 4'h0 : k + 4'h1;
            o_pin <= (k < (span >> 1));
        end
    end
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import timer_unit_pkg::*;
    typedef struct {string n; logic [15:0] v;} note_type;
    logic i_clk = 0;
    logic i_reset_n = 0;
    logic i_wr_en = 0;
    logic [3:0] i_wr_sel = 0;
    logic [3:0] i_rd_sel = 0;
    logic [3:0] per0 = 4;
    logic [15:0] i_wr_data = 0;
    logic [15:0] o_rd_data;
    logic [15:0] v;
    logic i_timer0_in, i_timer1_in, o_timer0_out, o_timer1_out;
    logic o_timer1_watchdog_irq_source, o_timer2_dma_req;
    logic run = 0;
    logic [2:0] o_timer_tc;
    logic [2:0] tc_d = 0;
    logic [3:0] sels[8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int prv[3];
    int e;
    bit have[3];
    bit sngl0 = 0;
    bit alt1 = 0;
    bit wd1 = 0;
    int tq[3][$];
    note_type rq[$];
    note_type nt;
    event rd_ev;

    triple_timer_unit u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_wr_en(i_wr_en), .i_wr_sel(i_wr_sel), .i_wr_data(i_wr_data),
        .i_rd_sel(i_rd_sel), .o_rd_data(o_rd_data),
        .i_timer0_in(i_timer0_in), .i_timer1_in(i_timer1_in),
        .o_timer0_out(o_timer0_out), .o_timer1_out(o_timer1_out),
        .o_timer1_watchdog_irq_source(o_timer1_watchdog_irq_source),
        .o_timer2_dma_req(o_timer2_dma_req), .o_timer_tc(o_timer_tc));
    pin_pulse_model u_pin0 (.i_clk(i_clk), .i_run(run), .i_period(per0),
        .o_pin(i_timer0_in));
    pin_pulse_model u_pin1 (.i_clk(i_clk), .i_run(run), .i_period(4'h8),
        .o_pin(i_timer1_in));

    initial begin
        forever #12.5 i_clk = ~i_clk;
    end

    task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // extra idle cycle keeps the strobe from being set twice in one step
    task automatic wr(logic [3:0] s, logic [15:0] d);
        i_wr_en = 1;
        i_wr_sel = s;
        i_wr_data = d;
        @(negedge i_clk);
        i_wr_en = 0;
        @(negedge i_clk);
    endtask
    task automatic rd(logic [3:0] s, logic [15:0] x, string n);
        i_rd_sel = s;
        rq.push_back(note_type'{n, x});
        @(negedge i_clk);
        -> rd_ev;
    endtask
    // counts zeroed too: a count above a new maximum would wrap 65536
    task automatic stop_all();
        wr(REG_T0_CTL, 0);
        wr(REG_T1_CTL, 0);
        wr(REG_T2_CTL, 0);
        wr(REG_T0_COUNT, 0);
        wr(REG_T1_COUNT, 0);
        wr(REG_T2_COUNT, 0);
        have = '{0, 0, 0};
        sngl0 = 0;
        alt1 = 0;
        wd1 = 0;
    endtask
    task automatic drain(int t);
        int k;
        k = 0;
        while (tq[t].size() > 0 && k < 400) begin
            @(negedge i_clk);
            k++;
        end
    endtask
    task automatic conclude();
        for (int t = 0; t < 3; t++) begin
            if (tq[t].size() > 0) begin
                num_errors++;
                $display("ERROR period%0d expected more pulses", t);
            end
        end
        if (num_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // read results taken oldest first
    always @(rd_ev) begin
        nt = rq.pop_front();
        check(nt.n, o_rd_data, nt.v);
    end
    always @(posedge i_clk) cyc <= cyc + 1;
    // terminal count spacing and the outputs tied to it
    always @(negedge i_clk) begin
        tc_d <= o_timer_tc;
        if (sngl0 && (o_timer_tc[0] || tc_d[0]))
            check("out0", o_timer0_out, !o_timer_tc[0]);
        if (o_timer_tc[1] || o_timer1_watchdog_irq_source)
            check("wdog", o_timer1_watchdog_irq_source,
                  wd1 && o_timer_tc[1]);
        if (o_timer_tc[2] || o_timer2_dma_req)
            check("dma", o_timer2_dma_req, o_timer_tc[2]);
        for (int t = 0; t < 3; t++) begin
            if (o_timer_tc[t] === 1'b1) begin
                if (have[t] && tq[t].size() > 0) begin
                    e = tq[t].pop_front();
                    check("period", 16'(cyc - prv[t]), 16'(e));
                    if (t == 1 && alt1)
                        check("out1", o_timer1_out, e == 20);
                end
                prv[t] = cyc;
                have[t] = 1;
            end
        end
    end

    initial begin
        #2000000;
        num_errors++;
        conclude();
    end

    initial begin
        void'($urandom(89511));
        repeat (2) @(negedge i_clk);
        i_reset_n = 1;
        // reset values, unmapped places read zero
        for (int i = 0; i < 16; i++)
            rd(i[3:0], 16'h0000, "reset");
        foreach (sels[i]) begin
            v = 16'($urandom);
            wr(sels[i], v);
            rd(sels[i], v, "rw");
        end
        wr(4'hB, 16'hFFFF);
        rd(4'hB, 16'h0000, "unmapped");
        stop_all();
        // timer 0, single maximum 5, internal clock/4
        wr(REG_T0_MAX_A, 16'h0005);
        sngl0 = 1;
        repeat (3) tq[0].push_back(20);
        wr(REG_T0_CTL, 16'h8001);
        drain(0);
        stop_all();
        // timer 1 alternating 3 and 5 with watchdog enabled
        wr(REG_T1_MAX_A, 16'h0003);
        wr(REG_T1_MAX_B, 16'h0005);
        alt1 = 1;
        wd1 = 1;
        tq[1] = '{20, 12, 20, 12};
        wr(REG_T1_CTL, 16'hA003);
        drain(1);
        stop_all();
        // timer 2 every 8 cycles prescales timer 0
        wr(REG_T2_MAX_A, 16'h0002);
        wr(REG_T0_MAX_A, 16'h0003);
        tq[2] = '{8, 8, 8, 8};
        tq[0] = '{24, 24};
        wr(REG_T2_CTL, 16'h8001);
        wr(REG_T0_CTL, 16'h8009);
        drain(0);
        drain(2);
        stop_all();
        // both pins clock their timers
        per0 = 4'($urandom_range(1, 2) * 4);
        wr(REG_T0_MAX_A, 16'h0004);
        wr(REG_T1_MAX_A, 16'h0002);
        // non-blocking: the pin models sample run on this same edge
        run <= 1'b1;
        repeat (3) tq[0].push_back(4 * per0);
        repeat (3) tq[1].push_back(16);
        wr(REG_T0_CTL, 16'h8005);
        // interrupt mask left off here: the watchdog interrupt must stay quiet
        wr(REG_T1_CTL, 16'h8005);
        drain(0);
        drain(1);
        run <= 1'b0;
        stop_all();
        // one-shot: enable drops, sticky flag set, count back at zero
        wr(REG_T0_MAX_A, 16'h0002);
        sngl0 = 1;
        wr(REG_T0_CTL, 16'h8000);
        repeat (24) @(negedge i_clk);
        rd(REG_T0_CTL, 16'h0020, "ctl0");
        rd(REG_T0_COUNT, 16'h0000, "count0");
        // reset with every timer stopped: registers cleared, outputs back to idle
        wr(REG_T1_COUNT, 16'h1234);
        rd(REG_T1_COUNT, 16'h1234, "count1");
        @(negedge i_clk);
        i_reset_n = 0;
        @(negedge i_clk);
        check("rst_rd", o_rd_data, 16'h0000);
        check("rst_out0", o_timer0_out, 16'h0001);
        i_reset_n = 1;
        rd(REG_T1_COUNT, 16'h0000, "rst_count1");
        rd(REG_T0_CTL, 16'h0000, "rst_ctl0");
        // let the last read's check run before the verdict
        repeat (2) @(negedge i_clk);
        conclude();
    end
endmodule
